/* src/instr_decoder.v */
`timescale 1ns/1ps
`include "instr_decoder_regs.vh"
// Contract
// - Each instruction is one 14-bit word: opcode plus operand fields.
// - Every word falls in exactly one group: byte, bit, or literal/control.
// - Byte ops take the register from the address field, destination from d.
// - d equal 0 stores result in W; d equal 1 stores to the register.
// - Register address field is seven bits, range 0x00 to 0x7F.
// - Bit field picks one of eight bit positions in the register.
// - Literal field is an 8-bit or an 11-bit constant by instruction.
// - One instruction cycle lasts four clock periods.
// - One cycle per instruction; skips and jumps take two, second a no-op.
// - Register instructions read, modify, then store the result.
// - The register read happens even when the instruction only writes it.
// - Reading the port register clears the pin-change mismatch condition.
// - Don't-care bits are ignored; either value decodes the same.
module instr_decoder #(
   parameter       STACK_DEPTH = 8,
   parameter [6:0] PORT_ADDR   = `PORT_ADDR_DEF
) (
   input  wire        core_clk_in,
   input  wire        sys_rst_in,
   input  wire [13:0] instr_in,
   output reg  [10:0] pc_out,
   input  wire [7:0]  port_pins_in,
   output reg  [7:0]  port_latch_out,
   output reg         port_change_flag_out,
   output reg         instr_cycle_out,
   input  wire [7:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest
);
   localparam [3:0] PH_Q1 = 4'b0001;
   localparam [3:0] PH_Q2 = 4'b0010;
   localparam [3:0] PH_Q3 = 4'b0100;
   localparam [3:0] PH_Q4 = 4'b1000;
   localparam [2:0] CLS_BYTE = 3'b001;
   localparam [2:0] CLS_BIT  = 3'b010;
   localparam [2:0] CLS_LIT  = 3'b100;

   // -------------------------------------------------------------------------
   // Decode functions
   // -------------------------------------------------------------------------
   function [2:0] decode_class;
      input [13:0] iw;
      begin
         if (iw[13:12] == `GRP_BIT) begin
            decode_class = CLS_BIT;
         end else if (iw[13] || iw[11:7] == 5'h00) begin
            decode_class = CLS_LIT;
         end else begin
            decode_class = CLS_BYTE;
         end
      end
   endfunction

   function names_file;
      input [13:0] iw;
      begin
         names_file = (decode_class(iw) == CLS_BIT) ||
                      (decode_class(iw) == CLS_BYTE && !(iw[11:8] == 4'h1 && !iw[7]));
      end
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   reg [3:0]  phase_q;
   reg [13:0] ir_q;
   reg        dummy_q;
   reg [10:0] pc_q;
   reg [7:0]  w_q;
   reg        c_q, dc_q, z_q;
   reg        to_q, powerdown_q;
   reg [7:0]  opnd_q;
   reg [7:0]  snap_q;
   reg        run_q;
   reg [2:0]  sp_q;
   reg [10:0] stack_q [0:STACK_DEPTH-1];
   reg [7:0]  res_q;
   reg        wr_f_q, wr_w_q, wr_flags_q, skip_q, jump_q, push_q, pop_q;
   reg        c_nq, dc_nq, z_nq, to_nq, powerdown_nq, wr_tp_q;
   reg [10:0] tgt_q;
   wire [7:0] mem_rdata;

   // -------------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------------
   wire [2:0]  cls     = decode_class(ir_q);
   wire [1:0]  grp     = ir_q[`GRP_MSB:`GRP_LSB];
   wire [3:0]  op      = ir_q[`OP_MSB:`OP_LSB];
   wire [6:0]  faddr   = ir_q[`FADDR_WIDTH-1:0];
   wire        dest_f  = ir_q[`DEST_BIT];
   wire [2:0]  bsel    = ir_q[`BSEL_MSB:`BSEL_LSB];
   wire [7:0]  k8      = ir_q[`K8_MSB:0];
   wire [10:0] k11     = ir_q[`K11_MSB:0];
   wire [7:0]  bmask   = 8'h01 << bsel;
   wire        use_f   = names_file(ir_q) && !dummy_q;
   wire        port_rd = use_f && faddr == PORT_ADDR && phase_q == PH_Q2;

   // -------------------------------------------------------------------------
   // Arithmetic
   // -------------------------------------------------------------------------
   wire [7:0] src   = (grp == `GRP_LIT) ? k8 : opnd_q;
   wire [8:0] add_s = {1'b0, src} + {1'b0, w_q};
   wire [4:0] add_h = {1'b0, src[3:0]} + {1'b0, w_q[3:0]};
   wire [8:0] sub_s = {1'b0, src} + {1'b0, ~w_q} + 9'h001;
   wire [4:0] sub_h = {1'b0, src[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
   wire [7:0] inc_v = opnd_q + 8'h01;
   wire [7:0] dec_v = opnd_q - 8'h01;

   reg [7:0]  res_d;
   reg        wr_f_d, wr_w_d, zf_d, cf_d, dcf_d, wz_d, wc_d, wdc_d;
   reg        skip_d, jump_d, push_d, pop_d, wtp_d, to_d, powerdown_d;
   reg [10:0] tgt_d;

   // -------------------------------------------------------------------------
   // Execute: operation per opcode
   // -------------------------------------------------------------------------
   always @* begin
      res_d  = 8'h00;
      wr_f_d = 1'b0;
      wr_w_d = 1'b0;
      wz_d   = 1'b0;
      wc_d   = 1'b0;
      wdc_d  = 1'b0;
      cf_d   = c_q;
      dcf_d  = dc_q;
      skip_d = 1'b0;
      jump_d = 1'b0;
      push_d = 1'b0;
      pop_d  = 1'b0;
      wtp_d  = 1'b0;
      to_d   = to_q;
      powerdown_d = powerdown_q;
      tgt_d  = k11;
      if (!dummy_q) begin
         case (grp)
            `GRP_BYTE: begin
               wr_f_d = dest_f;
               wr_w_d = !dest_f;
               wz_d   = 1'b1;
               case (op)
                  4'h0: begin
                     wz_d = 1'b0;
                     if (dest_f) begin
                        res_d = w_q;
                     end else begin
                        wr_w_d = 1'b0;
                        case (ir_q[6:0])
                           `CTL_RETURN, `CTL_RETFIE: begin
                              pop_d  = 1'b1;
                              jump_d = 1'b1;
                              tgt_d  = stack_q[sp_q - 3'd1];
                           end
                           `CTL_SLEEP: begin
                              wtp_d = 1'b1;
                              to_d  = 1'b1;
                              powerdown_d = 1'b0;
                           end
                           `CTL_CLRWDT: begin
                              wtp_d = 1'b1;
                              to_d  = 1'b1;
                              powerdown_d = 1'b1;
                           end
                           default: ;
                        endcase
                     end
                  end
                  4'h1: begin
                     res_d  = 8'h00;
                  end
                  4'h2: begin
                     res_d = sub_s[7:0];
                     wc_d  = 1'b1;
                     wdc_d = 1'b1;
                     cf_d  = sub_s[8];
                     dcf_d = sub_h[4];
                  end
                  4'h3: res_d = dec_v;
                  4'h4: res_d = opnd_q | w_q;
                  4'h5: res_d = opnd_q & w_q;
                  4'h6: res_d = opnd_q ^ w_q;
                  4'h7: begin
                     res_d = add_s[7:0];
                     wc_d  = 1'b1;
                     wdc_d = 1'b1;
                     cf_d  = add_s[8];
                     dcf_d = add_h[4];
                  end
                  4'h8: res_d = opnd_q;
                  4'h9: res_d = ~opnd_q;
                  4'ha: res_d = inc_v;
                  4'hb: begin
                     res_d  = dec_v;
                     wz_d   = 1'b0;
                     skip_d = (dec_v == 8'h00);
                  end
                  4'hc: begin
                     res_d = {c_q, opnd_q[7:1]};
                     wz_d  = 1'b0;
                     wc_d  = 1'b1;
                     cf_d  = opnd_q[0];
                  end
                  4'hd: begin
                     res_d = {opnd_q[6:0], c_q};
                     wz_d  = 1'b0;
                     wc_d  = 1'b1;
                     cf_d  = opnd_q[7];
                  end
                  4'he: begin
                     res_d = {opnd_q[3:0], opnd_q[7:4]};
                     wz_d  = 1'b0;
                  end
                  default: begin
                     res_d  = inc_v;
                     wz_d   = 1'b0;
                     skip_d = (inc_v == 8'h00);
                  end
               endcase
               if (op == 4'h1) begin
                  wr_f_d = dest_f;
                  wr_w_d = !dest_f;
               end
            end
            `GRP_BIT: begin
               case (op[3:2])
                  2'b00: begin
                     res_d  = opnd_q & ~bmask;
                     wr_f_d = 1'b1;
                  end
                  2'b01: begin
                     res_d  = opnd_q | bmask;
                     wr_f_d = 1'b1;
                  end
                  2'b10: skip_d = ((opnd_q & bmask) == 8'h00);
                  default: skip_d = ((opnd_q & bmask) != 8'h00);
               endcase
            end
            `GRP_JUMP: begin
               jump_d = 1'b1;
               push_d = !ir_q[11];
            end
            default: begin
               wr_w_d = 1'b1;
               case (op[3:2])
                  2'b00: res_d = k8;
                  2'b01: begin
                     res_d  = k8;
                     pop_d  = 1'b1;
                     jump_d = 1'b1;
                     tgt_d  = stack_q[sp_q - 3'd1];
                  end
                  2'b10: begin
                     wz_d = 1'b1;
                     case (op[1:0])
                        2'b00: res_d = k8 | w_q;
                        2'b01: res_d = k8 & w_q;
                        2'b10: res_d = k8 ^ w_q;
                        default: begin
                           wr_w_d = 1'b0;
                           wz_d   = 1'b0;
                        end
                     endcase
                  end
                  default: begin
                     wz_d  = 1'b1;
                     wc_d  = 1'b1;
                     wdc_d = 1'b1;
                     res_d = op[1] ? add_s[7:0] : sub_s[7:0];
                     cf_d  = op[1] ? add_s[8] : sub_s[8];
                     dcf_d = op[1] ? add_h[4] : sub_h[4];
                  end
               endcase
            end
         endcase
      end
      zf_d = wz_d ? (res_d == 8'h00) : z_q;
   end

   // -------------------------------------------------------------------------
   // File register storage
   // -------------------------------------------------------------------------
   wire wr_mem = phase_q == PH_Q4 && wr_f_q && faddr != PORT_ADDR;

   file_reg_mem #(
      .AW (`FADDR_WIDTH),
      .DW (`DATA_WIDTH)
   ) u_mem (
      .clk_in    (core_clk_in),
      .raddr_in  (faddr),
      .rdata_out (mem_rdata),
      .we_in     (wr_mem),
      .waddr_in  (faddr),
      .wdata_in  (res_q)
   );

   // -------------------------------------------------------------------------
   // Instruction cycle sequencing
   // -------------------------------------------------------------------------
   integer i;
   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         phase_q         <= PH_Q1;
         instr_cycle_out <= 1'b0;
         ir_q            <= 14'h0000;
         dummy_q         <= 1'b1;
         pc_q            <= 11'h000;
         pc_out          <= 11'h000;
         w_q             <= 8'h00;
         c_q             <= 1'b0;
         dc_q            <= 1'b0;
         z_q             <= 1'b0;
         to_q            <= `TO_RESET;
         powerdown_q     <= `POWERDOWN_RESET;
         opnd_q          <= 8'h00;
         snap_q          <= 8'h00;
         port_latch_out  <= 8'h00;
         sp_q            <= 3'd0;
         res_q           <= 8'h00;
         wr_f_q          <= 1'b0;
         wr_w_q          <= 1'b0;
         wr_flags_q      <= 1'b0;
         skip_q          <= 1'b0;
         jump_q          <= 1'b0;
         push_q          <= 1'b0;
         pop_q           <= 1'b0;
         c_nq            <= 1'b0;
         dc_nq           <= 1'b0;
         z_nq            <= 1'b0;
         to_nq           <= 1'b0;
         powerdown_nq    <= 1'b0;
         wr_tp_q         <= 1'b0;
         tgt_q           <= 11'h000;
         for (i = 0; i < STACK_DEPTH; i = i + 1) begin
            stack_q[i] <= 11'h000;
         end
      end else begin
         instr_cycle_out <= 1'b0;
         case (phase_q)
            PH_Q1: begin
               if (run_q) begin
                  phase_q <= PH_Q2;
               end
            end
            PH_Q2: begin
               phase_q <= PH_Q3;
               opnd_q  <= (faddr == PORT_ADDR) ? port_pins_in : mem_rdata;
               if (port_rd) begin
                  snap_q <= port_pins_in;
               end
            end
            PH_Q3: begin
               phase_q    <= PH_Q4;
               res_q      <= res_d;
               wr_f_q     <= wr_f_d;
               wr_w_q     <= wr_w_d;
               wr_flags_q <= !dummy_q;
               skip_q     <= skip_d;
               jump_q     <= jump_d;
               push_q     <= push_d;
               pop_q      <= pop_d;
               tgt_q      <= tgt_d;
               c_nq       <= wc_d ? cf_d : c_q;
               dc_nq      <= wdc_d ? dcf_d : dc_q;
               z_nq       <= zf_d;
               to_nq      <= to_d;
               powerdown_nq <= powerdown_d;
               wr_tp_q    <= wtp_d;
            end
            PH_Q4: begin
               phase_q         <= PH_Q1;
               instr_cycle_out <= 1'b1;
               if (wr_w_q) begin
                  w_q <= res_q;
               end
               if (wr_f_q && faddr == PORT_ADDR) begin
                  port_latch_out <= res_q;
               end
               if (wr_flags_q) begin
                  c_q  <= c_nq;
                  dc_q <= dc_nq;
                  z_q  <= z_nq;
               end
               if (wr_tp_q) begin
                  to_q <= to_nq;
                  powerdown_q <= powerdown_nq;
               end
               if (push_q) begin
                  stack_q[sp_q] <= pc_q;
                  sp_q          <= sp_q + 3'd1;
               end else if (pop_q) begin
                  sp_q <= sp_q - 3'd1;
               end
               ir_q    <= instr_in;
               dummy_q <= jump_q || skip_q;
               if (jump_q) begin
                  pc_q   <= tgt_q;
                  pc_out <= tgt_q;
               end else begin
                  pc_q   <= pc_out + 11'h001;
                  pc_out <= pc_out + 11'h001;
               end
               wr_f_q  <= 1'b0;
               wr_w_q  <= 1'b0;
               jump_q  <= 1'b0;
               skip_q  <= 1'b0;
               push_q  <= 1'b0;
               pop_q   <= 1'b0;
               wr_tp_q <= 1'b0;
            end
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Pin change flag, set wins over software clear
   // -------------------------------------------------------------------------
   wire req      = avs_read || avs_write;
   wire wr_fire  = avs_write && !avs_waitrequest;
   wire ctrl_wr  = wr_fire && avs_address == `ADDR_CTRL && avs_byteenable[0];
   wire sw_clr   = ctrl_wr && avs_writedata[`CTRL_CLRF_BIT];
   wire mismatch = port_pins_in != snap_q;

   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         port_change_flag_out <= 1'b0;
      end else begin
         port_change_flag_out <= mismatch || (port_change_flag_out && !sw_clr);
      end
   end

   // -------------------------------------------------------------------------
   // Register bus slave
   // -------------------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (avs_address)
         `ADDR_CTRL:   rd_mux = {31'h0, run_q};
         `ADDR_STATUS: rd_mux = {24'h0, port_change_flag_out, to_q, powerdown_q,
                                 dummy_q, 1'b0, dc_q, c_q, z_q};
         `ADDR_WREG:   rd_mux = {24'h0, w_q};
         `ADDR_PC:     rd_mux = {21'h0, pc_q};
         `ADDR_INSTR:  rd_mux = {13'h0, cls, 2'b00, ir_q};
         `ADDR_DECODE: rd_mux = {5'h0, k11, 5'h0, bsel, dest_f, faddr};
         default:      rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge core_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         run_q           <= `CTRL_RESET;
      end else begin
         if (req && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
         end else begin
            avs_waitrequest <= 1'b1;
         end
         if (ctrl_wr) begin
            run_q <= avs_writedata[`CTRL_RUN_BIT];
         end
      end
   end
endmodule // instr_decoder

/* src/instr_decoder_regs.vh */
`ifndef INSTR_DECODER_REGS_VH
`define INSTR_DECODER_REGS_VH

// ----------------------------------------------------------------------------
// Word and field layout
// ----------------------------------------------------------------------------
`define IW_WIDTH        14
`define FADDR_WIDTH     7
`define FADDR_MAX       7'h7f
`define DATA_WIDTH      8
`define PC_WIDTH        11
`define GRP_MSB         13
`define GRP_LSB         12
`define OP_MSB          11
`define OP_LSB          8
`define DEST_BIT        7
`define BSEL_MSB        9
`define BSEL_LSB        7
`define K8_MSB          7
`define K11_MSB         10

// ----------------------------------------------------------------------------
// Group codes in the two top bits
// ----------------------------------------------------------------------------
`define GRP_BYTE        2'b00
`define GRP_BIT         2'b01
`define GRP_JUMP        2'b10
`define GRP_LIT         2'b11

// ----------------------------------------------------------------------------
// Control words, low seven bits when bits 13:7 are zero
// ----------------------------------------------------------------------------
`define CTL_RETURN      7'h08
`define CTL_RETFIE      7'h09
`define CTL_SLEEP       7'h63
`define CTL_CLRWDT      7'h64

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define OSC_PER_INSTR   4
`define CORE_CLK_HZ     10000000
`define INSTR_CYCLE_NS  (`OSC_PER_INSTR * 1000000000 / `CORE_CLK_HZ)

// ----------------------------------------------------------------------------
// Register bus map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_WREG       8'h08
`define ADDR_PC         8'h0c
`define ADDR_INSTR      8'h10
`define ADDR_DECODE     8'h14
`define CTRL_RUN_BIT    0
`define CTRL_CLRF_BIT   1
`define CTRL_RESET      1'b1
`define PORT_ADDR_DEF   7'h05
`define TO_RESET        1'b1
`define POWERDOWN_RESET 1'b1

`endif

/* src/file_reg_mem.v */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// File register storage, registered read port
// ----------------------------------------------------------------------------
module file_reg_mem #(
   parameter AW = 7,
   parameter DW = 8
) (
   input  wire          clk_in,
   input  wire [AW-1:0] raddr_in,
   output reg  [DW-1:0] rdata_out,
   input  wire          we_in,
   input  wire [AW-1:0] waddr_in,
   input  wire [DW-1:0] wdata_in
);
   reg [DW-1:0] mem_q [0:(1<<AW)-1];

   always @(posedge clk_in) begin
      if (we_in) begin
         mem_q[waddr_in] <= wdata_in;
      end
      rdata_out <= mem_q[raddr_in];
   end
endmodule // file_reg_mem

/* sim/prog_mem.sv */
`timescale 1ns/1ps
module prog_mem (
   input  wire logic [10:0] fetch_addr_in,
   output wire logic [13:0] word_out
);
   logic [13:0] mem [0:2047];
   assign word_out = mem[fetch_addr_in];
endmodule // prog_mem

/* sim/instr_decoder_checker.sv */
`timescale 1ns/1ps
module instr_decoder_checker (
   input wire logic        core_clk_in,
   input wire logic        sys_rst_in,
   input wire logic [10:0] pc_out,
   input wire logic [7:0]  port_latch_out,
   input wire logic        port_change_flag_out,
   input wire logic        instr_cycle_out,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   wire req = avs_read || avs_write;
   sequence s_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   AST_CYC_GAP: assert property (instr_cycle_out |=> !instr_cycle_out [*3])
      else $error("cycle pulses too close");
   AST_PC_HOLD: assert property ($changed(pc_out) |=> $stable(pc_out) [*3])
      else $error("pc moved inside a cycle");
   AST_LATCH_AT_CYC:
      assert property ($changed(port_latch_out) |-> $rose(instr_cycle_out))
      else $error("latch store off cycle end");
   AST_FLAG_STICKY:
      assert property ($fell(port_change_flag_out) |-> $past(avs_write && !avs_waitrequest
         && avs_address == 8'h00 && avs_writedata[1])) else $error("flag dropped alone");
   AST_BUS_ANSWER: assert property (req && avs_waitrequest |=> s_answer)
      else $error("bus answer late");
   AST_BUS_CAUSE: assert property ($fell(avs_waitrequest) |-> $past(req))
      else $error("answer without request");
   AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
      else $error("read data moved");
   AST_BUS_IDLE: assert property (!req |=> avs_waitrequest)
      else $error("waitrequest low when idle");
endmodule // instr_decoder_checker
bind instr_decoder instr_decoder_checker u_chk (.core_clk_in, .sys_rst_in, .pc_out,
   .port_latch_out, .port_change_flag_out, .instr_cycle_out, .avs_address, .avs_read,
   .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

/* sim/fourteen_bit_instruction_decoder_tb_top.sv */
`timescale 1ns/1ps
module fourteen_bit_instruction_decoder_tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [13:0] iw;
   logic [10:0] pc;
   logic [7:0]  pins = 8'h00;
   logic [7:0]  latch;
   logic        flag;
   logic        cyc;
   int          exp_q[$];
   logic [7:0]  a = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [3:0]  be = 4'hf;
   logic [31:0] rdat;
   logic        wrq;
   logic [31:0] q;
   int          n_mismatch = 0;
   int          check_count = 0;
   int          k;
   int          b;
   always #50 clk = ~clk;
   prog_mem pm (.fetch_addr_in(pc), .word_out(iw));
   instr_decoder dut (.core_clk_in(clk), .sys_rst_in(rst), .instr_in(iw), .pc_out(pc),
      .port_pins_in(pins), .port_latch_out(latch), .port_change_flag_out(flag),
      .instr_cycle_out(cyc), .avs_address(a), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wrq));
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      a <= ad;
      wr <= w;
      rd <= !w;
      wd <= d;
      do @(posedge clk); while (wrq !== 1'b0);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task end_of_test;
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge clk);
      n_mismatch++;
      end_of_test;
   end
   initial begin
      void'($urandom(32'h5a95));
      repeat (2) begin
         k = $urandom_range(255);
         b = $urandom_range(7);
         pm.mem[0] = 14'h3300 | 14'(k); // Don't-care bits set
         pm.mem[1] = 14'h00a0;
         pm.mem[2] = 14'h0a20; // Result to W only
         pm.mem[3] = 14'h1420 | 14'(b << 7);
         pm.mem[4] = 14'h0085;
         pm.mem[5] = 14'h0820;
         pm.mem[6] = 14'h1c20 | 14'(b << 7); // Skip taken
         pm.mem[7] = 14'h3000;
         pm.mem[8] = 14'h0185; // Loop clears the port
         pm.mem[9] = 14'h2808;
         pins <= 8'h00;
         rst <= 1'b1;
         repeat (5) @(posedge clk);
         rst <= 1'b0;
         repeat (80) @(posedge clk);
         bus(1'b0, 8'h08, 32'h0);
         chk("w", q, 32'(k | (1 << b)));
         chk("latch", 32'(latch), 32'h0);
         bus(1'b0, 8'h04, 32'h0);
         chk("status", q & 32'hef, 32'h61);
         // Loop fetch order after the goto lands: clrf, goto, dummy
         exp_q = '{9, 10, 8};
         do @(posedge clk); while (pc !== 11'h008);
         chk("cycle", 32'(cyc), 32'h1);
         while (exp_q.size() > 0) begin
            repeat (4) @(posedge clk);
            chk("pc", 32'(pc), 32'(exp_q.pop_front()));
         end
         bus(1'b0, 8'h40, 32'h0);
         chk("unmapped", q, 32'h0);
         pins <= 8'(1 + $urandom_range(254));
         repeat (16) @(posedge clk);
         chk("flag set", 32'(flag), 32'h1);
         be <= 4'he;
         bus(1'b1, 8'h00, 32'h2);
         chk("flag kept", 32'(flag), 32'h1);
         be <= 4'hf;
         bus(1'b1, 8'h00, 32'h3);
         repeat (20) @(posedge clk);
         chk("flag clear", 32'(flag), 32'h0);
      end
      end_of_test;
   end
endmodule // fourteen_bit_instruction_decoder_tb_top
